// File: hdl/aes_staging_regs.sv
// Per-port ACL entry staging bank behind an AXI4-Lite slave.
// Assumes a single clock and a master that keeps one write and one read in flight.
//
// Our own choice: the AXI4-Lite register port.
`default_nettype none

module aes_staging_regs (
  input  wire logic                       sys_clk,
  input  wire logic                       reset,
  input  wire logic [aes_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                       s_axi_awvalid,
  output logic                            s_axi_awready,
  input  wire logic [aes_pkg::DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]                 s_axi_wstrb,
  input  wire logic                       s_axi_wvalid,
  output logic                            s_axi_wready,
  output logic      [1:0]                 s_axi_bresp,
  output logic                            s_axi_bvalid,
  input  wire logic                       s_axi_bready,
  input  wire logic [aes_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                       s_axi_arvalid,
  output logic                            s_axi_arready,
  output logic      [aes_pkg::DATA_W-1:0] s_axi_rdata,
  output logic      [1:0]                 s_axi_rresp,
  output logic                            s_axi_rvalid,
  input  wire logic                       s_axi_rready
);
  import aes_pkg::*;

  aes_state_t                state_q;
  logic                      aw_held_q;
  logic                      w_held_q;
  logic [ADDR_W-1:0]         awaddr_q;
  logic [DATA_W-1:0]         wdata_q;
  logic [3:0]                wstrb_q;
  logic [7:0]                stage_q [FIRST_STAGED:LAST_STAGED];
  logic [7:0]                sel_hi_q;
  logic [7:0]                sel_lo_q;
  logic                      dir_q;
  logic [3:0]                index_q;
  logic                      wr_done_q;
  logic                      rd_done_q;
  logic [ENTRY_BYTES-1:0]    xfer_en_q;
  logic [ENTRY_BYTES*8-1:0]  tbl_rdata;

  // Write channel decode
  wire [IDX_W-1:0]       wr_idx     = awaddr_q[IDX_W+1:2];
  wire                   wr_mapped  = (wr_idx >= IDX_MAC_23_16) && (wr_idx <= IDX_ACCESS_CTRL);
  wire                   wr_fire    = aw_held_q && w_held_q && !s_axi_bvalid && (state_q == AES_IDLE);
  wire                   wr_byte    = wr_fire && wr_mapped && wstrb_q[0];
  wire [7:0]             wr_val     = wdata_q[7:0];
  wire                   start      = wr_byte && (wr_idx == IDX_SEL_LOW);
  wire [ENTRY_BYTES-1:0] start_en;

  // Reversed select mapping, high bits to bytes 7..0, low bits to 15..8
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_sel_map
      assign start_en[gi]     = sel_hi_q[7-gi];
      assign start_en[gi + 8] = wr_val[7-gi];
    end
  endgenerate

  // Flat view of staging bytes; unstaged bytes read as zero
  wire [ENTRY_BYTES*8-1:0] stage_flat;
  generate
    for (gi = 0; gi < ENTRY_BYTES; gi++) begin : g_flat
      if (gi < FIRST_STAGED) begin : g_zero
        assign stage_flat[gi*8 +: 8] = 8'h00;
      end else begin : g_byte
        assign stage_flat[gi*8 +: 8] = stage_q[gi];
      end
    end
  endgenerate

  // Table access, only staged lanes that were selected
  wire tbl_we = (state_q == AES_WRITE_TBL);
  wire [ENTRY_BYTES-1:0] tbl_lanes = xfer_en_q & STAGED_MASK;

  aes_entry_table #(
    .ENTRIES (ENTRIES),
    .BYTES   (ENTRY_BYTES),
    .IDX_W   (4)
  ) u_table (
    .clk     (sys_clk),
    .reset   (reset),
    .idx     (index_q),
    .we      (tbl_we),
    .lane_en (tbl_lanes),
    .wdata   (stage_flat),
    .rdata_q (tbl_rdata)
  );

  // Staging bytes: bus writes between transfers, selected lanes on read load
  generate
    for (gi = FIRST_STAGED; gi <= LAST_STAGED; gi++) begin : g_stage
      wire bus_hit = wr_byte && (wr_idx == IDX_STAGE_BASE + IDX_W'(gi));
      wire load    = (state_q == AES_READ_LOAD) && xfer_en_q[gi];
      wire [7:0] stage_d = load ? tbl_rdata[gi*8 +: 8] : (bus_hit ? wr_val : stage_q[gi]);
      always_ff @(posedge sys_clk) begin
        if (reset) begin
          stage_q[gi] <= STAGE_RESET;
        end else begin
          stage_q[gi] <= stage_d;
        end
      end
    end
  endgenerate

  // Select and control registers
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      sel_hi_q <= SEL_RESET;
      sel_lo_q <= SEL_RESET;
      dir_q    <= 1'b0;
      index_q  <= 4'h0;
    end else if (wr_byte) begin
      if (wr_idx == IDX_SEL_HIGH) begin
        sel_hi_q <= wr_val;
      end
      if (wr_idx == IDX_SEL_LOW) begin
        sel_lo_q <= wr_val;
      end
      if (wr_idx == IDX_ACCESS_CTRL) begin
        dir_q   <= wr_val[CTRL_DIR];
        index_q <= wr_val[CTRL_IDX_HI:0];
      end
    end
  end

  // Transfer sequencer
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_q   <= AES_IDLE;
      xfer_en_q <= '0;
    end else begin
      unique case (state_q)
        AES_IDLE: begin
          if (start) begin
            xfer_en_q <= start_en;
            state_q   <= dir_q ? AES_WRITE_TBL : AES_READ_TBL;
          end
        end
        AES_WRITE_TBL: state_q <= AES_IDLE;
        AES_READ_TBL:  state_q <= AES_READ_LOAD;
        AES_READ_LOAD: state_q <= AES_IDLE;
      endcase
    end
  end

  // Completion flags, cleared at start, set when the transfer ends
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      wr_done_q <= 1'b1;
      rd_done_q <= 1'b1;
    end else begin
      if (start && dir_q) begin
        wr_done_q <= 1'b0;
      end else if (state_q == AES_WRITE_TBL) begin
        wr_done_q <= 1'b1;
      end
      if (start && !dir_q) begin
        rd_done_q <= 1'b0;
      end else if (state_q == AES_READ_LOAD) begin
        rd_done_q <= 1'b1;
      end
    end
  end

  // Write address and data capture, either order
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      aw_held_q     <= 1'b0;
      w_held_q      <= 1'b0;
      awaddr_q      <= '0;
      wdata_q       <= '0;
      wstrb_q       <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q     <= 1'b1;
        awaddr_q      <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end else if (wr_fire) begin
        aw_held_q     <= 1'b0;
        s_axi_awready <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q     <= 1'b1;
        wdata_q      <= s_axi_wdata;
        wstrb_q      <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end else if (wr_fire) begin
        w_held_q     <= 1'b0;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Write response
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Read decode and data selection
  wire [IDX_W-1:0] rd_idx    = s_axi_araddr[IDX_W+1:2];
  wire             rd_mapped = (rd_idx >= IDX_MAC_23_16) && (rd_idx <= IDX_ACCESS_CTRL);
  wire [7:0]       ctrl_rd   = {1'b0, wr_done_q, rd_done_q, dir_q, index_q};
  wire [7:0]       rd_byte   = (rd_idx == IDX_SEL_HIGH)    ? sel_hi_q :
                               (rd_idx == IDX_SEL_LOW)     ? sel_lo_q :
                               (rd_idx == IDX_ACCESS_CTRL) ? ctrl_rd  :
                               rd_mapped ? stage_flat[rd_idx[3:0]*8 +: 8] : 8'h00;

  // Read channel
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= {24'h000000, rd_byte};
      s_axi_rresp   <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
    end
  end

  // Field views of the action bytes, watched by the checks below
  wire [1:0] priority_mode_field    = stage_q[BYTE_A][PRIO_MODE_HI:PRIO_MODE_LO];
  wire [2:0] priority_field         = stage_q[BYTE_A][PRIO_HI:PRIO_LO];
  wire       remark_priority_enable = stage_q[BYTE_A][RMK_EN_BIT];
  wire [2:0] remark_priority        = {stage_q[BYTE_A][RMK_HI_HI:RMK_HI_LO], stage_q[BYTE_B][RMK_LO_BIT]};
  wire [1:0] map_mode_field         = stage_q[BYTE_B][MAP_MODE_HI:MAP_MODE_LO];
  wire [6:0] fwd_port_map           = stage_q[BYTE_D][FWD_HI:0];
  wire       bus_to_a = wr_byte && (wr_idx == IDX_PRIO_ACTION);
  wire       bus_to_b = wr_byte && (wr_idx == IDX_REMARK_MAP);
  wire       bus_to_d = wr_byte && (wr_idx == IDX_FWD_MAP);

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  // Transfer launch and lane mapping
  a_start_launch: assert property (start |=> state_q != AES_IDLE)
    else $error("transfer not launched by low select write");
  a_map_high: assert property (start |=> xfer_en_q[7] == $past(sel_hi_q[0])
                               && xfer_en_q[0] == $past(sel_hi_q[7]))
    else $error("high select lanes mis-mapped");
  a_map_low: assert property (start |=> xfer_en_q[15] == $past(wr_val[0]) && xfer_en_q[8] == $past(wr_val[7]))
    else $error("low select lanes mis-mapped");

  // Read load respects selection
  a_lane_kept: assert property ((state_q == AES_READ_LOAD) && !xfer_en_q[15] |=> $stable(stage_q[15]))
    else $error("unselected byte changed by read");
  a_lane_loaded: assert property ((state_q == AES_READ_LOAD) && xfer_en_q[15]
                                  |=> stage_q[15] == $past(tbl_rdata[127:120]))
    else $error("selected byte not loaded from table");

  // Completion sequencing
  sequence s_read_walk;
    !rd_done_q ##1 !rd_done_q ##1 rd_done_q;
  endsequence
  a_read_done: assert property (start && !dir_q |=> s_read_walk)
    else $error("read status timing wrong");
  a_write_done: assert property (start && dir_q |=> tbl_we && !wr_done_q ##1 wr_done_q)
    else $error("write transfer or status wrong");

  // Field layout and write response
  a_action_fields: assert property (bus_to_a |=> priority_mode_field == $past(wr_val[7:6])
                                    && priority_field == $past(wr_val[5:3])
                                    && remark_priority_enable == $past(wr_val[2]))
    else $error("byte A fields misplaced");
  a_remark_split: assert property (bus_to_b |=> remark_priority[0] == $past(wr_val[7])
                                   && map_mode_field == $past(wr_val[6:5]))
    else $error("remark priority low bit misplaced");
  a_fwd_map: assert property (bus_to_d |=> fwd_port_map == $past(wr_val[6:0]))
    else $error("forward map not stored");
  a_write_resp: assert property (wr_fire |=> s_axi_bvalid && s_axi_awready && s_axi_wready)
    else $error("write response missing");
endmodule // aes_staging_regs

`default_nettype wire

// File: common/aes_pkg.sv
// Constants shared by the ACL entry staging bank and its entry table.
// Assumes a 32-bit AXI4-Lite register bus with word-aligned registers.
`default_nettype none

package aes_pkg;
  // Bus geometry
  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;
  localparam int IDX_W  = 14;

  // Register indices as printed, byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_STAGE_BASE  = 14'h0600;
  localparam logic [IDX_W-1:0] IDX_MAC_23_16   = 14'h0605;
  localparam logic [IDX_W-1:0] IDX_MAC_15_8    = 14'h0606;
  localparam logic [IDX_W-1:0] IDX_MAC_7_0     = 14'h0607;
  localparam logic [IDX_W-1:0] IDX_ETYPE_HIGH  = 14'h0608;
  localparam logic [IDX_W-1:0] IDX_ETYPE_LOW   = 14'h0609;
  localparam logic [IDX_W-1:0] IDX_PRIO_ACTION = 14'h060a;
  localparam logic [IDX_W-1:0] IDX_REMARK_MAP  = 14'h060b;
  localparam logic [IDX_W-1:0] IDX_SPARE       = 14'h060c;
  localparam logic [IDX_W-1:0] IDX_FWD_MAP     = 14'h060d;
  localparam logic [IDX_W-1:0] IDX_RULESET_HI  = 14'h060e;
  localparam logic [IDX_W-1:0] IDX_RULESET_LO  = 14'h060f;
  localparam logic [IDX_W-1:0] IDX_SEL_HIGH    = 14'h0610;
  localparam logic [IDX_W-1:0] IDX_SEL_LOW     = 14'h0611;
  localparam logic [IDX_W-1:0] IDX_ACCESS_CTRL = 14'h0612;

  // Entry geometry
  localparam int ENTRIES      = 16;
  localparam int ENTRY_BYTES  = 16;
  localparam int FIRST_STAGED = 5;
  localparam int LAST_STAGED  = 15;
  localparam int BYTE_A       = 10;
  localparam int BYTE_B       = 11;
  localparam int BYTE_D       = 13;
  localparam logic [ENTRY_BYTES-1:0] STAGED_MASK = 16'hffe0;

  // Reset values
  localparam logic [7:0] STAGE_RESET = 8'h00;
  localparam logic [7:0] SEL_RESET   = 8'h00;

  // Field positions
  localparam int PRIO_MODE_HI = 7;
  localparam int PRIO_MODE_LO = 6;
  localparam int PRIO_HI      = 5;
  localparam int PRIO_LO      = 3;
  localparam int RMK_EN_BIT   = 2;
  localparam int RMK_HI_HI    = 1;
  localparam int RMK_HI_LO    = 0;
  localparam int RMK_LO_BIT   = 7;
  localparam int MAP_MODE_HI  = 6;
  localparam int MAP_MODE_LO  = 5;
  localparam int FWD_HI       = 6;
  localparam int CTRL_WSTAT   = 6;
  localparam int CTRL_RSTAT   = 5;
  localparam int CTRL_DIR     = 4;
  localparam int CTRL_IDX_HI  = 3;

  // Responses
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    AES_IDLE,
    AES_WRITE_TBL,
    AES_READ_TBL,
    AES_READ_LOAD
  } aes_state_t;
endpackage : aes_pkg

`default_nettype wire

// File: hdl/aes_entry_table.sv
// ACL entry table: indexed entries with per-byte write lanes.
// Assumes one access per cycle from the staging bank; read data is registered.
`default_nettype none

module aes_entry_table #(
  parameter int ENTRIES = 16,
  parameter int BYTES   = 16,
  parameter int IDX_W   = 4
) (
  input  wire logic                 clk,
  input  wire logic                 reset,
  input  wire logic [IDX_W-1:0]     idx,
  input  wire logic                 we,
  input  wire logic [BYTES-1:0]     lane_en,
  input  wire logic [BYTES*8-1:0]   wdata,
  output logic      [BYTES*8-1:0]   rdata_q
);
  logic [BYTES*8-1:0] mem_q [ENTRIES];

  // Byte-lane writes into the indexed entry
  always_ff @(posedge clk) begin
    if (reset) begin
      for (int e = 0; e < ENTRIES; e++) begin
        mem_q[e] <= '0;
      end
    end else if (we) begin
      for (int b = 0; b < BYTES; b++) begin
        if (lane_en[b]) begin
          mem_q[idx][b*8 +: 8] <= wdata[b*8 +: 8];
        end
      end
    end
  end

  // Registered read of the indexed entry
  always_ff @(posedge clk) begin
    if (reset) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= mem_q[idx];
    end
  end
endmodule // aes_entry_table

`default_nettype wire

// File: sim/acl_entry_staging_regs_tb.sv
// Self-checking bench for the ACL entry staging bank.
// Assumes aes_pkg and the staging bank with its entry table are compiled first.
`default_nettype none

module acl_entry_staging_regs_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import aes_pkg::*;

  logic              sys_clk;
  logic              reset;
  logic [ADDR_W-1:0] s_axi_awaddr;
  logic              s_axi_awvalid;
  logic              s_axi_awready;
  logic [DATA_W-1:0] s_axi_wdata;
  logic [3:0]        s_axi_wstrb;
  logic              s_axi_wvalid;
  logic              s_axi_wready;
  logic [1:0]        s_axi_bresp;
  logic              s_axi_bvalid;
  logic              s_axi_bready;
  logic [ADDR_W-1:0] s_axi_araddr;
  logic              s_axi_arvalid;
  logic              s_axi_arready;
  logic [DATA_W-1:0] s_axi_rdata;
  logic [1:0]        s_axi_rresp;
  logic              s_axi_rvalid;
  logic              s_axi_rready;
  int                errors;
  int                checks;
  int                cycles;
  int                i;

  aes_staging_regs DUT (
    .sys_clk(sys_clk), .reset(reset),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
  );

  // Clock and hang guard
  initial sys_clk = 1'b0;
  always #2.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      end_sim();
    end
  end

  // Verdict and end of run
  task automatic end_sim();
    if (errors == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  // One write: address and data offered together, bready kept high
  task automatic axi_wr(input logic [13:0] idx, input logic [7:0] val, input logic [3:0] strb,
                        input logic [1:0] exp_resp);
    logic aw_done;
    logic w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    s_axi_awaddr  <= {idx, 2'b00};
    s_axi_wdata   <= {24'h000000, val};
    s_axi_wstrb   <= strb;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    forever begin
      @(posedge sys_clk);
      if (aw_done && w_done && s_axi_bvalid) begin
        chk("bresp", {30'h0, exp_resp}, {30'h0, s_axi_bresp});
        break;
      end
      if (!aw_done && s_axi_awready) begin
        aw_done = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_done && s_axi_wready) begin
        w_done = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
  endtask

  task automatic wr(input logic [13:0] idx, input logic [7:0] val);
    axi_wr(idx, val, 4'h1, RESP_OKAY);
  endtask

  // One read, rready kept high
  task automatic axi_rd(input logic [13:0] idx, output logic [31:0] data, output logic [1:0] resp);
    logic ar_done;
    ar_done = 1'b0;
    s_axi_araddr  <= {idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    forever begin
      @(posedge sys_clk);
      if (ar_done && s_axi_rvalid) begin
        data = s_axi_rdata;
        resp = s_axi_rresp;
        break;
      end
      if (!ar_done && s_axi_arready) begin
        ar_done = 1'b1;
        s_axi_arvalid <= 1'b0;
      end
    end
  endtask

  task automatic rd_chk(input logic [13:0] idx, input logic [7:0] exp, input logic [1:0] exp_resp);
    logic [31:0] d;
    logic [1:0]  r;
    axi_rd(idx, d, r);
    chk($sformatf("reg_%h", idx), {24'h0, exp}, d);
    chk($sformatf("rresp_%h", idx), {30'h0, exp_resp}, {30'h0, r});
  endtask

  // Poll a completion flag of the access control register
  task automatic poll_done(input int bitpos);
    logic [31:0] d;
    logic [1:0]  r;
    for (int n = 0; n < 32; n++) begin
      axi_rd(IDX_ACCESS_CTRL, d, r);
      if (d[bitpos] === 1'b1) break;
    end
    chk("done_flag", 32'h1, {31'h0, d[bitpos]});
  endtask

  // Lane of staged byte b under a select pair
  function automatic logic lane(input logic [7:0] hi, input logic [7:0] lo, input int b);
    return (b < 8) ? hi[7-b] : lo[15-b];
  endfunction

  function automatic logic [7:0] pat(input int b);
    return {b[3:0], 4'h0} ^ 8'h5a;
  endfunction

  // Entry 3 content after the sparse table write
  function automatic logic [7:0] entry3(input int b);
    return lane(8'h05, 8'h5a, b) ? pat(b) : 8'h00;
  endfunction

  initial begin
    errors = 0;
    checks = 0;
    cycles = 0;
    reset = 1'b1;
    s_axi_awaddr = '0;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = '0;
    s_axi_wstrb = 4'h0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b1;
    s_axi_araddr = '0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b1;
    repeat (10) @(posedge sys_clk);
    reset <= 1'b0;
    // Reset values and unmapped place
    for (i = FIRST_STAGED; i <= LAST_STAGED; i++) rd_chk(IDX_STAGE_BASE + 14'(i), STAGE_RESET, RESP_OKAY);
    rd_chk(IDX_SEL_HIGH, SEL_RESET, RESP_OKAY);
    rd_chk(IDX_SEL_LOW, SEL_RESET, RESP_OKAY);
    rd_chk(IDX_ACCESS_CTRL, 8'h60, RESP_OKAY);
    axi_wr(IDX_STAGE_BASE, 8'hff, 4'h1, RESP_SLVERR);
    rd_chk(IDX_STAGE_BASE, 8'h00, RESP_SLVERR);
    // Plain storage of every staged byte, field bytes included
    for (i = FIRST_STAGED; i <= LAST_STAGED; i++) wr(IDX_STAGE_BASE + 14'(i), pat(i));
    for (i = FIRST_STAGED; i <= LAST_STAGED; i++) rd_chk(IDX_STAGE_BASE + 14'(i), pat(i), RESP_OKAY);
    axi_wr(IDX_MAC_23_16, 8'h00, 4'h0, RESP_OKAY);
    rd_chk(IDX_MAC_23_16, pat(5), RESP_OKAY);
    // Sparse table write of entry 3
    wr(IDX_ACCESS_CTRL, 8'h13);
    wr(IDX_SEL_HIGH, 8'h05);
    wr(IDX_SEL_LOW, 8'h5a);
    poll_done(CTRL_WSTAT);
    rd_chk(IDX_ACCESS_CTRL, 8'h73, RESP_OKAY);
    // Clear the bank, then read entry 3 with every lane
    for (i = FIRST_STAGED; i <= LAST_STAGED; i++) wr(IDX_STAGE_BASE + 14'(i), 8'h00);
    wr(IDX_ACCESS_CTRL, 8'h03);
    wr(IDX_SEL_HIGH, 8'hff);
    wr(IDX_SEL_LOW, 8'hff);
    poll_done(CTRL_RSTAT);
    for (i = FIRST_STAGED; i <= LAST_STAGED; i++) rd_chk(IDX_STAGE_BASE + 14'(i), entry3(i), RESP_OKAY);
    // Partial read over a background pattern
    for (i = FIRST_STAGED; i <= LAST_STAGED; i++) wr(IDX_STAGE_BASE + 14'(i), 8'haa);
    wr(IDX_SEL_HIGH, 8'h04);
    wr(IDX_SEL_LOW, 8'h01);
    poll_done(CTRL_RSTAT);
    for (i = FIRST_STAGED; i <= LAST_STAGED; i++)
      rd_chk(IDX_STAGE_BASE + 14'(i), lane(8'h04, 8'h01, i) ? entry3(i) : 8'haa, RESP_OKAY);
    // Untouched entry 4 read into byte 14 only
    wr(IDX_ACCESS_CTRL, 8'h04);
    wr(IDX_SEL_HIGH, 8'h00);
    wr(IDX_SEL_LOW, 8'h02);
    poll_done(CTRL_RSTAT);
    rd_chk(IDX_RULESET_HI, 8'h00, RESP_OKAY);
    rd_chk(IDX_FWD_MAP, 8'haa, RESP_OKAY);
    rd_chk(IDX_ACCESS_CTRL, 8'h64, RESP_OKAY);
    end_sim();
  end
endmodule // acl_entry_staging_regs_tb

`default_nettype wire
